// [logic/vtxhr_pkg.sv]
package vtxhr_pkg;

	localparam int unsigned TOPO_W = 5;
	localparam int unsigned DWORD_W = 32;
	localparam int unsigned HDR_W = 256;
	localparam int unsigned PW_W = 11;
	localparam int unsigned CLIP_W = 8;

	// Header field positions
	localparam int unsigned DW_MISC = 3;
	localparam int unsigned DW_POS_X = 4;
	localparam int unsigned DW_POS_Y = 5;
	localparam int unsigned DW_POS_Z = 6;
	localparam int unsigned DW_RHW = 7;
	localparam int unsigned PW_LSB = 8;
	localparam int unsigned CLIP_LSB = 0;

	// Readback point of this instance in the pipeline
	localparam logic [1:0] RB_GS_INPUT = 2'h0;
	localparam logic [1:0] RB_PRE_CLIP = 2'h1;
	localparam logic [1:0] RB_POST_CLIP = 2'h2;

	// Topology codes of the two dot-set topologies; plain defaults
	localparam logic [TOPO_W-1:0] TOPO_DOT_SET = 5'h01;
	localparam logic [TOPO_W-1:0] TOPO_DOT_SET_BACKFACE = 5'h02;

	localparam int unsigned FIFO_DEPTH = 8;

	typedef enum logic [1:0] {
		VTXHR_IDLE,
		VTXHR_WAIT,
		VTXHR_OUT
	} vtxhr_phase_t;

	function automatic logic vtxhr_is_dot(input logic [TOPO_W-1:0] t);
		return (t == TOPO_DOT_SET) || (t == TOPO_DOT_SET_BACKFACE);
	endfunction

endpackage

// [logic/vtxhr_fifo.sv]
module vtxhr_fifo #(
	parameter int unsigned WIDTH = 8,
	parameter int unsigned DEPTH = 8
) (
	input  wire logic             clk_i,
	input  wire logic             rst_i,
	input  wire logic             ce_i,
	input  wire logic             in_valid_i,
	output logic                  in_ready_o,
	input  wire logic [WIDTH-1:0] in_data_i,
	output logic                  out_valid_o,
	input  wire logic             out_ready_i,
	output logic [WIDTH-1:0]      out_data_o
);
	localparam int unsigned PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam int unsigned CW = $clog2(DEPTH + 1);

	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [PW-1:0]               wr_ptr;
		logic [PW-1:0]               rd_ptr;
		logic [CW-1:0]               cnt;
		logic                        rdy;
		logic                        vld;
	} vtxhr_fifo_state_t;

	vtxhr_fifo_state_t st_q;
	vtxhr_fifo_state_t st_d;
	logic              push;
	logic              pop;

	assign in_ready_o = st_q.rdy;
	assign out_valid_o = st_q.vld;
	assign out_data_o = st_q.mem[st_q.rd_ptr];

	always_comb begin
		st_d = st_q;
		push = ce_i && in_valid_i && st_q.rdy;
		pop = ce_i && out_ready_i && st_q.vld;
		if (push) begin
			st_d.mem[st_q.wr_ptr] = in_data_i;
			st_d.wr_ptr = (st_q.wr_ptr == PW'(DEPTH - 1)) ? '0
				: st_q.wr_ptr + 1'b1;
		end
		if (pop) begin
			st_d.rd_ptr = (st_q.rd_ptr == PW'(DEPTH - 1)) ? '0
				: st_q.rd_ptr + 1'b1;
		end
		if (push && !pop) begin
			st_d.cnt = st_q.cnt + 1'b1;
		end else if (pop && !push) begin
			st_d.cnt = st_q.cnt - 1'b1;
		end
		// Registered flags keep both handshakes glitch free
		st_d.rdy = st_d.cnt < CW'(DEPTH);
		st_d.vld = st_d.cnt != '0;
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			st_q <= '0;
			st_q.rdy <= 1'b1;
		end else begin
			st_q <= st_d;
		end
	end

endmodule

// [logic/vtxhr_hdr_decode.sv]
module vtxhr_hdr_decode
	import vtxhr_pkg::*;
(
	input  wire logic [vtxhr_pkg::HDR_W-1:0]   hdr_i,
	input  wire logic [vtxhr_pkg::TOPO_W-1:0]  topology_i,
	input  wire logic                          from_clip_i,
	input  wire logic [vtxhr_pkg::CLIP_W-1:0]  clip_mask_i,
	output logic [vtxhr_pkg::PW_W-1:0]         point_width_o,
	output logic [vtxhr_pkg::CLIP_W-1:0]       clip_bits_o,
	output logic [vtxhr_pkg::DWORD_W-1:0]      pos_x_o,
	output logic [vtxhr_pkg::DWORD_W-1:0]      pos_y_o,
	output logic [vtxhr_pkg::DWORD_W-1:0]      pos_z_o,
	output logic [vtxhr_pkg::DWORD_W-1:0]      rhw_o
);
	logic [DWORD_W-1:0] misc;

	// Dwords 0 to 2 and misc bits above the width never looked at
	assign misc = hdr_i[DW_MISC*DWORD_W +: DWORD_W];

	// Width zeroed for non-dot topologies
	assign point_width_o = vtxhr_is_dot(topology_i)
		? misc[PW_LSB +: PW_W] : '0;

	// Clipper output has no use for outside bits
	assign clip_bits_o = from_clip_i ? '0
		: (misc[CLIP_LSB +: CLIP_W] & clip_mask_i);

	assign pos_x_o = hdr_i[DW_POS_X*DWORD_W +: DWORD_W];
	assign pos_y_o = hdr_i[DW_POS_Y*DWORD_W +: DWORD_W];
	assign pos_z_o = hdr_i[DW_POS_Z*DWORD_W +: DWORD_W];
	assign rhw_o = hdr_i[DW_RHW*DWORD_W +: DWORD_W];

endmodule

// [logic/vtxhr_top.sv]
module vtxhr_top
	import vtxhr_pkg::*;
#(
	parameter int unsigned           HANDLE_W = 10,
	parameter int unsigned           OWNER_W  = 3,
	parameter int unsigned           SEQ_W    = 8,
	parameter int unsigned           VCNT_W   = 8,
	parameter logic [OWNER_W-1:0]    OWNER_ID = '0
) (
	input  wire logic                          clk_i,
	input  wire logic                          rst_i,
	input  wire logic                          ce_i,
	input  wire logic                          in_valid_i,
	output logic                               in_ready_o,
	input  wire logic [HANDLE_W-1:0]           in_handle_i,
	input  wire logic [vtxhr_pkg::TOPO_W-1:0]  in_topology_i,
	input  wire logic                          in_first_i,
	input  wire logic                          in_last_i,
	input  wire logic [OWNER_W-1:0]            in_owner_i,
	input  wire logic [SEQ_W-1:0]              in_seq_i,
	input  wire logic                          in_from_clip_i,
	input  wire logic [1:0]                    readback_point_i,
	input  wire logic [vtxhr_pkg::CLIP_W-1:0]  clip_enable_mask_i,
	input  wire logic                          gen_mode_i,
	input  wire logic [vtxhr_pkg::TOPO_W-1:0]  gen_topology_i,
	input  wire logic [VCNT_W-1:0]             gen_vertex_count_i,
	output logic                               rd_req_o,
	output logic [HANDLE_W-1:0]                rd_handle_o,
	input  wire logic                          rd_valid_i,
	input  wire logic [vtxhr_pkg::HDR_W-1:0]   rd_data_i,
	output logic                               out_valid_o,
	input  wire logic                          out_ready_i,
	output logic [HANDLE_W-1:0]                out_handle_o,
	output logic [vtxhr_pkg::TOPO_W-1:0]       out_topology_o,
	output logic                               out_first_o,
	output logic                               out_last_o,
	output logic [OWNER_W-1:0]                 out_owner_o,
	output logic [SEQ_W-1:0]                   out_seq_o,
	output logic                               out_hdr_valid_o,
	output logic [vtxhr_pkg::PW_W-1:0]         out_point_width_o,
	output logic [vtxhr_pkg::CLIP_W-1:0]       out_clip_bits_o,
	output logic [vtxhr_pkg::DWORD_W-1:0]      out_pos_x_o,
	output logic [vtxhr_pkg::DWORD_W-1:0]      out_pos_y_o,
	output logic [vtxhr_pkg::DWORD_W-1:0]      out_pos_z_o,
	output logic [vtxhr_pkg::DWORD_W-1:0]      out_rhw_o
);
	localparam int unsigned PKT_W = HANDLE_W + TOPO_W + 2 + OWNER_W
		+ SEQ_W + 1;

	typedef struct packed {
		vtxhr_phase_t         phase;
		logic [HANDLE_W-1:0]  handle;
		logic [TOPO_W-1:0]    topo;
		logic                 first;
		logic                 last;
		logic [OWNER_W-1:0]   owner;
		logic [SEQ_W-1:0]     seq;
		logic                 from_clip;
		logic                 rd_req;
		logic                 out_valid;
		logic                 hdr_valid;
		logic [PW_W-1:0]      pw;
		logic [CLIP_W-1:0]    clip;
		logic [DWORD_W-1:0]   pos_x;
		logic [DWORD_W-1:0]   pos_y;
		logic [DWORD_W-1:0]   pos_z;
		logic [DWORD_W-1:0]   reciprocal_w;
		logic [VCNT_W-1:0]    vcount;
		logic [SEQ_W-1:0]     gen_seq;
	} vtxhr_state_t;

	vtxhr_state_t        st_q;
	vtxhr_state_t        st_d;
	logic [PKT_W-1:0]    in_word;
	logic [PKT_W-1:0]    head_word;
	logic                head_valid;
	logic                fifo_pop;
	logic [HANDLE_W-1:0] head_handle;
	logic [TOPO_W-1:0]   head_topo;
	logic                head_first;
	logic                head_last;
	logic [OWNER_W-1:0]  head_owner;
	logic [SEQ_W-1:0]    head_seq;
	logic                head_from_clip;
	logic                need_rb;
	logic                gen_last;
	logic [PW_W-1:0]     dec_pw;
	logic [CLIP_W-1:0]   dec_clip;
	logic [DWORD_W-1:0]  dec_x;
	logic [DWORD_W-1:0]  dec_y;
	logic [DWORD_W-1:0]  dec_z;
	logic [DWORD_W-1:0]  dec_rhw;

	// Packets ride as one word through the buffer
	assign in_word = {in_handle_i, in_topology_i, in_first_i, in_last_i,
		in_owner_i, in_seq_i, in_from_clip_i};
	assign {head_handle, head_topo, head_first, head_last, head_owner,
		head_seq, head_from_clip} = head_word;

	vtxhr_fifo #(
		.WIDTH (PKT_W),
		.DEPTH (FIFO_DEPTH)
	) u_fifo (
		.clk_i       (clk_i),
		.rst_i       (rst_i),
		.ce_i        (ce_i),
		.in_valid_i  (in_valid_i),
		.in_ready_o  (in_ready_o),
		.in_data_i   (in_word),
		.out_valid_o (head_valid),
		.out_ready_i (fifo_pop),
		.out_data_o  (head_word)
	);

	// Decode straight from the read data so it lands in one edge
	vtxhr_hdr_decode u_dec (
		.hdr_i         (rd_data_i),
		.topology_i    (st_q.topo),
		.from_clip_i   (st_q.from_clip),
		.clip_mask_i   (clip_enable_mask_i),
		.point_width_o (dec_pw),
		.clip_bits_o   (dec_clip),
		.pos_x_o       (dec_x),
		.pos_y_o       (dec_y),
		.pos_z_o       (dec_z),
		.rhw_o         (dec_rhw)
	);

	// Post-clip point skips entries that threads upstream of it made
	assign need_rb = (readback_point_i != RB_POST_CLIP)
		|| head_from_clip;

	// Count of zero or one makes single-vertex topologies
	assign gen_last = (gen_vertex_count_i <= VCNT_W'(1))
		|| (st_q.vcount == gen_vertex_count_i - VCNT_W'(1));

	always_comb begin
		st_d = st_q;
		fifo_pop = 1'b0;
		if (ce_i) begin
			case (st_q.phase)
			VTXHR_IDLE: begin
				if (head_valid) begin
					fifo_pop = 1'b1;
					st_d.handle = head_handle;
					st_d.from_clip = head_from_clip;
					st_d.hdr_valid = 1'b0;
					st_d.pw = '0;
					st_d.clip = '0;
					st_d.pos_x = '0;
					st_d.pos_y = '0;
					st_d.pos_z = '0;
					st_d.reciprocal_w = '0;
					if (gen_mode_i) begin
						st_d.topo = gen_topology_i;
						st_d.first = st_q.vcount == '0;
						st_d.last = gen_last;
						st_d.owner = OWNER_ID;
						st_d.seq = st_q.gen_seq;
						st_d.gen_seq = st_q.gen_seq + 1'b1;
						st_d.vcount = gen_last ? '0
							: st_q.vcount + 1'b1;
					end else begin
						st_d.topo = head_topo;
						st_d.first = head_first;
						st_d.last = head_last;
						st_d.owner = head_owner;
						st_d.seq = head_seq;
					end
					if (need_rb) begin
						st_d.rd_req = 1'b1;
						st_d.phase = VTXHR_WAIT;
					end else begin
						st_d.out_valid = 1'b1;
						st_d.phase = VTXHR_OUT;
					end
				end
			end
			VTXHR_WAIT: begin
				// Only the 256 header bits are fetched; the rest stays put
				if (rd_valid_i) begin
					st_d.rd_req = 1'b0;
					st_d.hdr_valid = 1'b1;
					st_d.pw = dec_pw;
					st_d.clip = dec_clip;
					st_d.pos_x = dec_x;
					st_d.pos_y = dec_y;
					st_d.pos_z = dec_z;
					st_d.reciprocal_w = dec_rhw;
					st_d.out_valid = 1'b1;
					st_d.phase = VTXHR_OUT;
				end
			end
			VTXHR_OUT: begin
				if (out_ready_i) begin
					st_d.out_valid = 1'b0;
					st_d.phase = VTXHR_IDLE;
				end
			end
			default: begin
				st_d = '0;
			end
			endcase
		end
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end

	assign rd_req_o = st_q.rd_req;
	assign rd_handle_o = st_q.handle;
	assign out_valid_o = st_q.out_valid;
	assign out_handle_o = st_q.handle;
	assign out_topology_o = st_q.topo;
	assign out_first_o = st_q.first;
	assign out_last_o = st_q.last;
	assign out_owner_o = st_q.owner;
	assign out_seq_o = st_q.seq;
	assign out_hdr_valid_o = st_q.hdr_valid;
	assign out_point_width_o = st_q.pw;
	assign out_clip_bits_o = st_q.clip;
	assign out_pos_x_o = st_q.pos_x;
	assign out_pos_y_o = st_q.pos_y;
	assign out_pos_z_o = st_q.pos_z;
	assign out_rhw_o = st_q.reciprocal_w;

	// Checks sample only on enabled edges, as the logic does
	default clocking vtxhr_cb @(posedge clk_i iff ce_i);
	endclocking
	default disable iff (rst_i);

	sequence skip_pop_s;
		fifo_pop && !need_rb;
	endsequence

	sequence bare_out_s;
		out_valid_o && !out_hdr_valid_o && !rd_req_o;
	endsequence

	sequence fwd_pop_s;
		fifo_pop && !gen_mode_i;
	endsequence

	out_hold_a: assert property (
		out_valid_o && !out_ready_i |=> out_valid_o
			&& $stable(out_handle_o) && $stable(out_pos_x_o))
		else $error("output packet changed while stalled");

	rd_handle_a: assert property (
		rd_req_o && rd_valid_i |=> out_valid_o && out_hdr_valid_o
			&& out_handle_o == $past(rd_handle_o))
		else $error("answered handle not the requested one");

	topo_pass_a: assert property (
		fwd_pop_s |=> out_topology_o == $past(head_topo)
			&& out_first_o == $past(head_first)
			&& out_last_o == $past(head_last))
		else $error("forwarded topology altered");

	gen_first_a: assert property (
		fifo_pop && gen_mode_i |=>
			out_first_o == ($past(st_q.vcount) == '0)
			&& out_topology_o == $past(gen_topology_i))
		else $error("generated first marker wrong");

	gen_last_a: assert property (
		fifo_pop && gen_mode_i && gen_vertex_count_i > VCNT_W'(1)
			&& st_q.vcount == '0 |=> !out_last_o)
		else $error("last marker on opening vertex");

	gen_seq_a: assert property (
		fifo_pop && gen_mode_i |=> out_owner_o == OWNER_ID
			&& out_seq_o == $past(st_q.gen_seq))
		else $error("generated debug tags wrong");

	pre_clip_rb_a: assert property (
		fifo_pop && readback_point_i != RB_POST_CLIP
			|=> rd_req_o && !out_valid_o)
		else $error("entry not read back before clipper");

	post_skip_a: assert property (
		skip_pop_s |=> bare_out_s)
		else $error("readback issued for non-clipper entry");

	dot_width_a: assert property (
		out_valid_o && !vtxhr_is_dot(out_topology_o)
			|-> out_point_width_o == '0)
		else $error("point width on non-dot topology");

	clip_ignore_a: assert property (
		out_valid_o && st_q.from_clip |-> out_clip_bits_o == '0)
		else $error("outside bits kept for clipper vertex");

endmodule

// [verif/vtxhr_mem_model.sv]
module vtxhr_mem_model
	import vtxhr_pkg::*;
(
	input  wire logic                   clk_i,
	input  wire logic                   rst_i,
	input  wire logic                   ce_i,
	input  wire logic [3:0]             lat_i,
	input  wire logic                   rd_req_i,
	input  wire logic [9:0]             rd_handle_i,
	output logic                        rd_valid_o,
	output logic [vtxhr_pkg::HDR_W-1:0] rd_data_o
);
	timeunit 1ns;
	timeprecision 100ps;

	logic [3:0] wait_q;

	// Reserved dwords hold junk on purpose: the reader must ignore them
	function automatic logic [255:0] make_hdr(input logic [9:0] h);
		return {32'hBF800000 | 32'(h), 32'h40400000 | 32'(h),
			32'h40000000 | 32'(h), 32'h3F800000 | 32'(h),
			{13'h1ABC, 1'b1, h, h[7:0] ^ 8'hC3},
			{3{32'hDEAD0000 | 32'(h)}}};
	endfunction

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			rd_valid_o <= 1'b0;
			rd_data_o  <= '0;
			wait_q     <= 4'h0;
		end else if (ce_i) begin
			rd_valid_o <= 1'b0;
			// Data flips outside the pulse so stale words never match
			rd_data_o  <= ~rd_data_o;
			if (rd_req_i && !rd_valid_o) begin
				if (wait_q == lat_i) begin
					rd_valid_o <= 1'b1;
					rd_data_o  <= make_hdr(rd_handle_i);
					wait_q     <= 4'h0;
				end else begin
					wait_q <= wait_q + 4'h1;
				end
			end
		end
	end
endmodule

// [verif/tb.sv]
module tb;
	import vtxhr_pkg::*;
	timeunit 1ns;
	timeprecision 100ps;

	logic         clk_i, rst_i, ce_i, in_valid_i, in_first_i, in_last_i;
	logic         in_from_clip_i, gen_mode_i, out_ready_i, rd_valid_i;
	logic         in_ready_o, rd_req_o, out_valid_o, out_first_o;
	logic         out_last_o, out_hdr_valid_o;
	logic [9:0]   in_handle_i, rd_handle_o, out_handle_o;
	logic [4:0]   in_topology_i, gen_topology_i, out_topology_o;
	logic [2:0]   in_owner_i, out_owner_o;
	logic [7:0]   in_seq_i, clip_enable_mask_i, gen_vertex_count_i;
	logic [7:0]   out_seq_o, out_clip_bits_o, gcnt, gseq;
	logic [1:0]   readback_point_i;
	logic [3:0]   lat;
	logic [10:0]  out_point_width_o;
	logic [31:0]  out_pos_x_o, out_pos_y_o, out_pos_z_o, out_rhw_o;
	logic [255:0] rd_data_i;
	logic [175:0] exp_q[$];
	int           n_fail, cmp_count, cyc;
	wire  [175:0] out_sig = {out_handle_o, out_topology_o, out_first_o,
		out_last_o, out_owner_o, out_seq_o, out_hdr_valid_o,
		out_point_width_o, out_clip_bits_o, out_pos_x_o, out_pos_y_o,
		out_pos_z_o, out_rhw_o};

	vtxhr_top #(.OWNER_ID(3'h5)) vtxhr_top_inst (.clk_i, .rst_i, .ce_i,
		.in_valid_i, .in_ready_o, .in_handle_i, .in_topology_i, .in_first_i,
		.in_last_i, .in_owner_i, .in_seq_i, .in_from_clip_i,
		.readback_point_i, .clip_enable_mask_i, .gen_mode_i, .gen_topology_i,
		.gen_vertex_count_i, .rd_req_o, .rd_handle_o, .rd_valid_i, .rd_data_i,
		.out_valid_o, .out_ready_i, .out_handle_o, .out_topology_o,
		.out_first_o, .out_last_o, .out_owner_o, .out_seq_o, .out_hdr_valid_o,
		.out_point_width_o, .out_clip_bits_o, .out_pos_x_o, .out_pos_y_o,
		.out_pos_z_o, .out_rhw_o);

	vtxhr_mem_model vtxhr_mem_model_inst (.clk_i, .rst_i, .ce_i,
		.lat_i(lat), .rd_req_i(rd_req_o), .rd_handle_i(rd_handle_o),
		.rd_valid_o(rd_valid_i), .rd_data_o(rd_data_i));

	always #12.5 clk_i = ~clk_i;

	task automatic check(input logic [175:0] got, input logic [175:0] exp);
		cmp_count++;
		if (got !== exp) begin
			n_fail++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic conclude();
		$display("compares %0d mismatches %0d", cmp_count, n_fail);
		if (n_fail == 0 && cmp_count > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	function automatic logic [4:0] topo(input int i);
		return i % 3 == 0 ? TOPO_DOT_SET :
			i % 3 == 1 ? TOPO_DOT_SET_BACKFACE : 5'h04;
	endfunction

	function automatic logic [175:0] expect_pkt(input logic [9:0] h,
			input logic [4:0] t, input logic f, input logic l,
			input logic [2:0] o, input logic [7:0] s, input logic c);
		logic [255:0] d;
		logic [10:0]  pw;
		logic [7:0]   cb;
		d = vtxhr_mem_model_inst.make_hdr(h);
		pw = (t == TOPO_DOT_SET || t == TOPO_DOT_SET_BACKFACE) ?
			d[114:104] : 11'h000;
		cb = c ? 8'h00 : d[103:96] & clip_enable_mask_i;
		if (readback_point_i == 2'h2 && !c)
			return {h, t, f, l, o, s, 1'b0, 11'h000, 8'h00, 128'h0};
		return {h, t, f, l, o, s, 1'b1, pw, cb, d[159:128], d[191:160],
			d[223:192], d[255:224]};
	endfunction

	// Expectation is booked at the accepting edge, so config must be steady
	task automatic send(input logic [9:0] h, input logic [4:0] t,
			input logic f, input logic l, input logic c);
		logic gf;
		logic gl;
		in_valid_i     <= 1'b1;
		in_handle_i    <= h;
		in_topology_i  <= t;
		in_first_i     <= f;
		in_last_i      <= l;
		in_owner_i     <= h[2:0];
		in_seq_i       <= h[7:0];
		in_from_clip_i <= c;
		// Ready judged settled before the edge, not in its time step
		do @(negedge clk_i); while (in_ready_o !== 1'b1 || ce_i !== 1'b1);
		@(posedge clk_i);
		gf = gcnt == 8'h00;
		gl = gcnt == gen_vertex_count_i - 8'h01 || gen_vertex_count_i <= 8'h01;
		if (gen_mode_i) begin
			exp_q.push_back(expect_pkt(h, gen_topology_i, gf, gl, 3'h5, gseq, c));
			gcnt = gl ? 8'h00 : gcnt + 8'h01;
			gseq++;
		end else begin
			exp_q.push_back(expect_pkt(h, t, f, l, h[2:0], h[7:0], c));
		end
	endtask

	task automatic drain(input string name);
		in_valid_i <= 1'b0;
		for (int k = 0; k < 300 && exp_q.size() != 0; k++) @(posedge clk_i);
		check(176'(exp_q.size()), 176'h0);
		$display("test %s done", name);
	endtask

	// Ceiling well above the few hundred cycles the tests need
	always @(posedge clk_i) begin
		cyc++;
		if (cyc == 5000) begin
			n_fail++;
			conclude();
		end
	end

	// Compared half a cycle before the edge that takes the packet
	always @(negedge clk_i) begin
		if (!rst_i && ce_i && out_valid_o === 1'b1 && out_ready_i) begin
			if (exp_q.size() == 0)
				check(out_sig, '1);
			else
				check(out_sig, exp_q.pop_front());
		end
	end

	initial begin
		{clk_i, in_valid_i, in_handle_i, in_topology_i, in_first_i} = '0;
		{in_last_i, in_owner_i, in_seq_i, in_from_clip_i, gen_mode_i} = '0;
		{gen_topology_i, gen_vertex_count_i, gcnt, gseq, lat} = '0;
		{n_fail, cmp_count, cyc} = '0;
		{rst_i, ce_i, out_ready_i} = 3'h7;
		readback_point_i = 2'h1;
		clip_enable_mask_i = 8'h3C;
		repeat (3) @(posedge clk_i);
		check(176'({out_valid_o, rd_req_o, in_ready_o}), 176'h1);
		check(out_sig, 176'h0);
		rst_i <= 1'b0;
		for (int i = 0; i < 6; i++)
			send(10'h100 + 10'(i), topo(i), i == 0, i == 5, i[0]);
		drain("pre_clip");
		readback_point_i <= 2'h2;
		clip_enable_mask_i <= 8'hFF;
		lat <= 4'h3;
		for (int i = 0; i < 6; i++)
			send(10'h200 + 10'(i), topo(i), i == 0, i == 5, i[0]);
		ce_i <= 1'b0;
		repeat (3) @(posedge clk_i);
		ce_i <= 1'b1;
		drain("post_clip");
		for (int r = 0; r < 4; r += 3) begin
			readback_point_i <= 2'(r);
			lat <= 4'h1;
			send(10'h300 + 10'(r), TOPO_DOT_SET, 1'b1, 1'b0, 1'b0);
			send(10'h301 + 10'(r), TOPO_DOT_SET, 1'b0, 1'b1, 1'b1);
			drain("geom_point");
		end
		readback_point_i <= 2'h2;
		out_ready_i <= 1'b0;
		fork
			for (int i = 0; i < 12; i++)
				send(10'h080 + 10'(i), 5'h04, 1'b0, 1'b0, 1'b0);
			begin
				repeat (30) @(posedge clk_i);
				check(176'(in_ready_o), 176'h0);
				out_ready_i <= 1'b1;
			end
		join
		drain("fifo_full");
		gen_mode_i <= 1'b1;
		gen_topology_i <= TOPO_DOT_SET;
		gen_vertex_count_i <= 8'h03;
		readback_point_i <= 2'h1;
		for (int i = 0; i < 6; i++)
			send(10'h040 + 10'(i), 5'h04, 1'b0, 1'b0, 1'b0);
		drain("gen_three");
		gen_vertex_count_i <= 8'h01;
		send(10'h050, 5'h04, 1'b0, 1'b0, 1'b0);
		send(10'h051, 5'h04, 1'b0, 1'b0, 1'b0);
		drain("gen_single");
		conclude();
	end
endmodule
